// File: design/sfm_defines.svh
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SFM_OFF_CTRL        12'h000
`define SFM_OFF_STATUS      12'h004
`define SFM_OFF_MAX_SPEED   12'h008
`define SFM_OFF_DEV_LIMIT   12'h00C
`define SFM_OFF_SAT_TIME    12'h010
`define SFM_OFF_TRQ_LEVEL   12'h014
`define SFM_OFF_TRQ_TIME    12'h018
`define SFM_OFF_CRC_RUN     12'h01C
`define SFM_OFF_ENC_RES     12'h020
`define SFM_OFF_TURN_OFS    12'h024
`define SFM_OFF_ENC_TYPE    12'h028
`define SFM_OFF_MODEL       12'h02C
`define SFM_OFF_COMM_TMO    12'h030
`define SFM_OFF_CF_RUN      12'h034

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define SFM_CTRL_CLEAR_BIT  0
`define SFM_CTRL_ENABLE_BIT 1
`define SFM_RST_CTRL        32'h0000_0002
`define SFM_RST_MAX_SPEED   32'h0000_1388
`define SFM_RST_DEV_LIMIT   32'h0001_0000
`define SFM_RST_SAT_TIME    32'h0003_D090
`define SFM_RST_TRQ_LEVEL   32'h0000_8000
`define SFM_RST_TRQ_TIME    32'h0003_D090
`define SFM_RST_CRC_RUN     32'h0000_0003
`define SFM_RST_ENC_RES     32'h0002_0000
`define SFM_RST_ENC_TYPE    32'h0000_0000
`define SFM_RST_MODEL       32'h0000_0000
`define SFM_RST_COMM_TMO    32'h0000_C350
`define SFM_RST_CF_RUN      32'h0000_0003

// ---------------------------------------------------------------
// Fault codes and limits
// ---------------------------------------------------------------
`define SFM_CODE_NONE       8'h00
`define SFM_CODE_OVERSPEED  8'h01
`define SFM_CODE_OVERVOLT   8'h02
`define SFM_CODE_UNDERVOLT  8'h03
`define SFM_CODE_POS_TOL    8'h04
`define SFM_CODE_SPD_SAT    8'h06
`define SFM_CODE_INHIBIT    8'h07
`define SFM_CODE_DEV_OVF    8'h08
`define SFM_CODE_RELAY      8'h12
`define SFM_CODE_BRAKE      8'h13
`define SFM_CODE_ENC_PARAM  8'h16
`define SFM_CODE_TRQ_OVL    8'h1D
`define SFM_CODE_HALL       8'h20
`define SFM_CODE_MODEL      8'h29
`define SFM_CODE_ENC_NONE   8'h32
`define SFM_CODE_ENC_LOST   8'h33
`define SFM_CODE_BAT_LOW    8'h34
`define SFM_CODE_BAT_ERR    8'h35
`define SFM_CODE_CRC        8'h37
`define SFM_CODE_FB_LONG    8'h38
`define SFM_CODE_FB_FMT     8'h39
`define SFM_CODE_TURN_OFS   8'h3A
`define SFM_CODE_CF         8'h3B
`define SFM_DEV_OVF_LIMIT   32'h4000_0000
`define SFM_ENC_TYPE_MAX    4'h2

`endif

// File: design/sfm_pkg.sv
package sfm_pkg;

    // Monitor inputs grouped by source
    typedef struct packed {
        logic [31:0] speed;
        logic [31:0] pos_dev;
        logic        over_volt;
        logic        under_volt;
        logic        spd_sat;
        logic [31:0] torque;
        logic        inhibit_fwd_on;
        logic        inhibit_rev_on;
        logic        relay_cmd;
        logic        relay_sense;
        logic        brake_released;
        logic        cmd_pulse;
        logic [2:0]  hall_phase_signals;
        logic [7:0]  motor_model;
    } sfm_drive_t;

    typedef struct packed {
        logic        frame_valid;
        logic        crc_ok;
        logic        bat_low;
        logic        bat_err;
        logic        cf_err;
    } sfm_enc_t;

    typedef struct packed {
        logic        frame_too_long;
        logic        frame_bad_format;
    } sfm_fbus_t;

    typedef enum logic [1:0] {
        SFM_LINK_WAIT = 2'b00,
        SFM_LINK_UP   = 2'b01,
        SFM_LINK_LOST = 2'b11
    } sfm_link_t;

endpackage : sfm_pkg

// File: design/sfm_monitor.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "sfm_defines.svh"

// Notes on behaviour
// - Code 1 when measured speed exceeds the set maximum speed.
// - Code 2 on supply overvoltage, code 3 on undervoltage.
// - Code 4 when position deviation exceeds the set limit.
// - Code 6 when speed regulator saturates longer than a set time.
// - Code 7 when both travel inhibit inputs are off together.
// - Code 8 when absolute deviation exceeds two to the thirtieth.
// - Code 18 when sensed relay state differs from the command.
// - Code 19 on command pulses while the brake is still held.
// - Code 22 when the encoder type setting is unsupported.
// - Code 29 when torque exceeds a set level for a set time.
// - Code 32 when hall phases are all high or all low.
// - Code 41 when connected motor differs from the selected model.
// - Code 50 when the encoder link never comes up after power-up.
// - Code 51 when an established encoder link is lost.
// - Code 52 on low battery, 53 on battery data error.
// - Code 55 after a configurable run of encoder CRC failures.
// - Code 56 when a field-bus frame is too long.
// - Code 57 on bad field-bus settings, address or value.
// - Code 58 when single-turn offset is at least the resolution.
// - Code 59 when the encoder repeatedly reports control field errors.
module sfm_monitor (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire sfm_pkg::sfm_drive_t drv,
    input  wire sfm_pkg::sfm_enc_t   enc,
    input  wire sfm_pkg::sfm_fbus_t  fbus,
    output logic [7:0]              fault_code,
    output logic                    fault_active
);
    import sfm_pkg::*;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] max_speed_reg;
    logic [31:0] dev_limit_reg;
    logic [31:0] sat_time_reg;
    logic [31:0] trq_level_reg;
    logic [31:0] trq_time_reg;
    logic [31:0] crc_run_reg;
    logic [31:0] enc_res_reg;
    logic [31:0] turn_ofs_reg;
    logic [31:0] enc_type_reg;
    logic [31:0] model_reg;
    logic [31:0] comm_tmo_reg;
    logic [31:0] cf_run_reg;
    logic [7:0]  code_reg;
    logic [7:0]  code_next;
    logic [31:0] sat_cnt_reg;
    logic [31:0] trq_cnt_reg;
    logic [31:0] tmo_cnt_reg;
    logic [7:0]  crc_cnt_reg;
    logic [7:0]  cf_cnt_reg;
    sfm_link_t   link_reg;
    logic [31:0] rdata_reg;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire         acc      = psel & penable;
    wire         wr_acc   = acc & pwrite;
    wire         rd_setup = psel & ~penable & ~pwrite;
    wire         enabled  = ctrl_reg[`SFM_CTRL_ENABLE_BIT];

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    wire         mapped   = hit(paddr, `SFM_OFF_CTRL) | hit(paddr, `SFM_OFF_STATUS) |
                            hit(paddr, `SFM_OFF_MAX_SPEED) | hit(paddr, `SFM_OFF_DEV_LIMIT) |
                            hit(paddr, `SFM_OFF_SAT_TIME) | hit(paddr, `SFM_OFF_TRQ_LEVEL) |
                            hit(paddr, `SFM_OFF_TRQ_TIME) | hit(paddr, `SFM_OFF_CRC_RUN) |
                            hit(paddr, `SFM_OFF_ENC_RES) | hit(paddr, `SFM_OFF_TURN_OFS) |
                            hit(paddr, `SFM_OFF_ENC_TYPE) | hit(paddr, `SFM_OFF_MODEL) |
                            hit(paddr, `SFM_OFF_COMM_TMO) | hit(paddr, `SFM_OFF_CF_RUN);
    wire         clr_req  = wr_acc & hit(paddr, `SFM_OFF_CTRL) & pwdata[`SFM_CTRL_CLEAR_BIT];

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = rdata_reg;

    wire [31:0] rd_mux =
        hit(paddr, `SFM_OFF_CTRL)      ? {30'h0, ctrl_reg[1], 1'b0} :
        hit(paddr, `SFM_OFF_STATUS)    ? {22'h0, link_reg, code_reg} :
        hit(paddr, `SFM_OFF_MAX_SPEED) ? max_speed_reg :
        hit(paddr, `SFM_OFF_DEV_LIMIT) ? dev_limit_reg :
        hit(paddr, `SFM_OFF_SAT_TIME)  ? sat_time_reg :
        hit(paddr, `SFM_OFF_TRQ_LEVEL) ? trq_level_reg :
        hit(paddr, `SFM_OFF_TRQ_TIME)  ? trq_time_reg :
        hit(paddr, `SFM_OFF_CRC_RUN)   ? crc_run_reg :
        hit(paddr, `SFM_OFF_ENC_RES)   ? enc_res_reg :
        hit(paddr, `SFM_OFF_TURN_OFS)  ? turn_ofs_reg :
        hit(paddr, `SFM_OFF_ENC_TYPE)  ? enc_type_reg :
        hit(paddr, `SFM_OFF_MODEL)     ? model_reg :
        hit(paddr, `SFM_OFF_COMM_TMO)  ? comm_tmo_reg :
        hit(paddr, `SFM_OFF_CF_RUN)    ? cf_run_reg : 32'h0000_0000;

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_reg      <= `SFM_RST_CTRL;
            max_speed_reg <= `SFM_RST_MAX_SPEED;
            dev_limit_reg <= `SFM_RST_DEV_LIMIT;
            sat_time_reg  <= `SFM_RST_SAT_TIME;
            trq_level_reg <= `SFM_RST_TRQ_LEVEL;
            trq_time_reg  <= `SFM_RST_TRQ_TIME;
            crc_run_reg   <= `SFM_RST_CRC_RUN;
            enc_res_reg   <= `SFM_RST_ENC_RES;
            turn_ofs_reg  <= 32'h0000_0000;
            enc_type_reg  <= `SFM_RST_ENC_TYPE;
            model_reg     <= `SFM_RST_MODEL;
            comm_tmo_reg  <= `SFM_RST_COMM_TMO;
            cf_run_reg    <= `SFM_RST_CF_RUN;
            rdata_reg     <= 32'h0000_0000;
        end else begin
            // Read data loads in setup so it stands through the access cycle
            if (rd_setup) begin
                rdata_reg <= rd_mux;
            end
            if (wr_acc) begin
                if (hit(paddr, `SFM_OFF_CTRL))      ctrl_reg      <= {30'h0, pwdata[1], 1'b0};
                if (hit(paddr, `SFM_OFF_MAX_SPEED)) max_speed_reg <= pwdata;
                if (hit(paddr, `SFM_OFF_DEV_LIMIT)) dev_limit_reg <= pwdata;
                if (hit(paddr, `SFM_OFF_SAT_TIME))  sat_time_reg  <= pwdata;
                if (hit(paddr, `SFM_OFF_TRQ_LEVEL)) trq_level_reg <= pwdata;
                if (hit(paddr, `SFM_OFF_TRQ_TIME))  trq_time_reg  <= pwdata;
                if (hit(paddr, `SFM_OFF_CRC_RUN))   crc_run_reg   <= pwdata;
                if (hit(paddr, `SFM_OFF_ENC_RES))   enc_res_reg   <= pwdata;
                if (hit(paddr, `SFM_OFF_TURN_OFS))  turn_ofs_reg  <= pwdata;
                if (hit(paddr, `SFM_OFF_ENC_TYPE))  enc_type_reg  <= pwdata;
                if (hit(paddr, `SFM_OFF_MODEL))     model_reg     <= pwdata;
                if (hit(paddr, `SFM_OFF_COMM_TMO))  comm_tmo_reg  <= pwdata;
                if (hit(paddr, `SFM_OFF_CF_RUN))    cf_run_reg    <= pwdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // Timers and run counters
    // ---------------------------------------------------------------
    wire         trq_over  = drv.torque > trq_level_reg;
    wire         crc_bad   = enc.frame_valid & ~enc.crc_ok;
    wire         cf_bad    = enc.frame_valid & enc.crc_ok & enc.cf_err;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sat_cnt_reg <= 32'h0000_0000;
            trq_cnt_reg <= 32'h0000_0000;
            crc_cnt_reg <= 8'h00;
            cf_cnt_reg  <= 8'h00;
        end else begin
            sat_cnt_reg <= drv.spd_sat ? sat_cnt_reg + ((sat_cnt_reg != 32'hFFFF_FFFF) ? 32'h1 : 32'h0)
                                       : 32'h0000_0000;
            trq_cnt_reg <= trq_over ? trq_cnt_reg + ((trq_cnt_reg != 32'hFFFF_FFFF) ? 32'h1 : 32'h0)
                                    : 32'h0000_0000;
            if (crc_bad) begin
                crc_cnt_reg <= (crc_cnt_reg != 8'hFF) ? crc_cnt_reg + 8'h01 : crc_cnt_reg;
            end else if (enc.frame_valid) begin
                crc_cnt_reg <= 8'h00;
            end
            if (cf_bad) begin
                cf_cnt_reg <= (cf_cnt_reg != 8'hFF) ? cf_cnt_reg + 8'h01 : cf_cnt_reg;
            end else if (enc.frame_valid & enc.crc_ok) begin
                cf_cnt_reg <= 8'h00;
            end
        end
    end

    // ---------------------------------------------------------------
    // Encoder link state
    // ---------------------------------------------------------------
    wire good_frame = enc.frame_valid & enc.crc_ok;
    wire tmo_hit    = tmo_cnt_reg >= comm_tmo_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link_reg    <= SFM_LINK_WAIT;
            tmo_cnt_reg <= 32'h0000_0000;
        end else begin
            tmo_cnt_reg <= (good_frame | tmo_hit) ? 32'h0000_0000 : tmo_cnt_reg + 32'h1;
            case (link_reg)
                SFM_LINK_WAIT: begin
                    if (good_frame) link_reg <= SFM_LINK_UP;
                end
                SFM_LINK_UP: begin
                    if (tmo_hit & ~good_frame) link_reg <= SFM_LINK_LOST;
                end
                SFM_LINK_LOST: begin
                    if (good_frame) link_reg <= SFM_LINK_UP;
                end
                default: link_reg <= SFM_LINK_WAIT;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Fault detection
    // ---------------------------------------------------------------
    wire [31:0] dev_abs = drv.pos_dev[31] ? (~drv.pos_dev + 32'h1) : drv.pos_dev;
    wire [2:0]  hall    = drv.hall_phase_signals;

    wire f_ovs   = drv.speed > max_speed_reg;
    wire f_ov    = drv.over_volt;
    wire f_uv    = drv.under_volt;
    wire f_tol   = dev_abs > dev_limit_reg;
    wire f_sat   = drv.spd_sat & (sat_cnt_reg >= sat_time_reg);
    wire f_inh   = ~drv.inhibit_fwd_on & ~drv.inhibit_rev_on;
    wire f_dovf  = dev_abs > `SFM_DEV_OVF_LIMIT;
    wire f_rly   = drv.relay_cmd != drv.relay_sense;
    wire f_brk   = drv.cmd_pulse & ~drv.brake_released;
    wire f_etyp  = enc_type_reg > {28'h0, `SFM_ENC_TYPE_MAX};
    wire f_trq   = trq_over & (trq_cnt_reg >= trq_time_reg);
    wire f_hall  = (hall == 3'b111) | (hall == 3'b000);
    wire f_model = drv.motor_model != model_reg[7:0];
    wire f_none  = (link_reg == SFM_LINK_WAIT) & tmo_hit;
    wire f_lost  = link_reg == SFM_LINK_LOST;
    wire f_batl  = enc.frame_valid & enc.bat_low & ~enc.bat_err;
    wire f_bate  = enc.frame_valid & enc.bat_err;
    wire f_crc   = (crc_run_reg[7:0] != 8'h00) & (crc_cnt_reg >= crc_run_reg[7:0]);
    wire f_long  = fbus.frame_too_long;
    wire f_fmt   = fbus.frame_bad_format;
    wire f_ofs   = turn_ofs_reg >= enc_res_reg;
    wire f_cf    = (cf_run_reg[7:0] != 8'h00) & (cf_cnt_reg >= cf_run_reg[7:0]);

    // Fixed priority among faults seen in the same cycle, lowest code first
    wire [7:0] det_code =
        f_ovs   ? `SFM_CODE_OVERSPEED :
        f_ov    ? `SFM_CODE_OVERVOLT  :
        f_uv    ? `SFM_CODE_UNDERVOLT :
        f_tol   ? `SFM_CODE_POS_TOL   :
        f_sat   ? `SFM_CODE_SPD_SAT   :
        f_inh   ? `SFM_CODE_INHIBIT   :
        f_dovf  ? `SFM_CODE_DEV_OVF   :
        f_rly   ? `SFM_CODE_RELAY     :
        f_brk   ? `SFM_CODE_BRAKE     :
        f_etyp  ? `SFM_CODE_ENC_PARAM :
        f_trq   ? `SFM_CODE_TRQ_OVL   :
        f_hall  ? `SFM_CODE_HALL      :
        f_model ? `SFM_CODE_MODEL     :
        f_none  ? `SFM_CODE_ENC_NONE  :
        f_lost  ? `SFM_CODE_ENC_LOST  :
        f_batl  ? `SFM_CODE_BAT_LOW   :
        f_bate  ? `SFM_CODE_BAT_ERR   :
        f_crc   ? `SFM_CODE_CRC       :
        f_long  ? `SFM_CODE_FB_LONG   :
        f_fmt   ? `SFM_CODE_FB_FMT    :
        f_ofs   ? `SFM_CODE_TURN_OFS  :
        f_cf    ? `SFM_CODE_CF        : `SFM_CODE_NONE;

    wire det_any = enabled & (det_code != `SFM_CODE_NONE);
    wire held    = code_reg != `SFM_CODE_NONE;

    // ---------------------------------------------------------------
    // Fault latch
    // ---------------------------------------------------------------
    // Detection in the clear cycle wins over the clear
    assign code_next = held ? (clr_req ? (det_any ? det_code : `SFM_CODE_NONE) : code_reg)
                            : (det_any ? det_code : `SFM_CODE_NONE);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            code_reg <= `SFM_CODE_NONE;
        end else begin
            code_reg <= code_next;
        end
    end

    assign fault_code   = code_reg;
    assign fault_active = held;

endmodule : sfm_monitor

// File: test/sfm_monitor_properties.sv
`timescale 1ns/1ns
// ----------------------------------------
// Fault monitor checker
// ----------------------------------------
module sfm_monitor_properties (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire sfm_pkg::sfm_drive_t drv,
    input wire sfm_pkg::sfm_enc_t   enc,
    input wire sfm_pkg::sfm_fbus_t  fbus,
    input wire logic [7:0]          fault_code,
    input wire logic                fault_active
);
    import sfm_pkg::*;
    logic clr_wr;
    logic idle;
    logic en_reg;
    assign clr_wr = psel && penable && pwrite && (paddr == 12'h000) && pwdata[0];
    assign idle   = (fault_code == 8'h00) && en_reg;
    // Shadow of the enable bit, so detection checks stay quiet while monitoring is off
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            en_reg <= 1'b1;
        end else if (psel && penable && pwrite && (paddr == 12'h000)) begin
            en_reg <= pwdata[1];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    flag_tracks_a: assert property (fault_active == (fault_code != 8'h00))
        else $error("fault flag disagrees with code");
    code_held_a: assert property ((fault_code != 8'h00) && !clr_wr |=> $stable(fault_code))
        else $error("held code changed without clear");
    over_volt_a: assert property (idle && drv.over_volt |=> fault_code inside {8'h01, 8'h02})
        else $error("overvoltage code missing");
    under_volt_a: assert property (idle && drv.under_volt && !drv.over_volt |=> fault_code inside {8'h01, 8'h03})
        else $error("undervoltage code missing");
    inhibit_both_a: assert property (idle && !drv.inhibit_fwd_on && !drv.inhibit_rev_on |=> fault_code inside {[8'h01:8'h07]})
        else $error("inhibit code missing");
    relay_diff_a: assert property (idle && (drv.relay_cmd != drv.relay_sense) |=> fault_code inside {[8'h01:8'h12]})
        else $error("relay code missing");
    brake_pulse_a: assert property (idle && drv.cmd_pulse && !drv.brake_released |=> fault_code inside {[8'h01:8'h13]})
        else $error("brake code missing");
    hall_code_a: assert property (idle && (drv.hall_phase_signals inside {3'h0, 3'h7}) |=> fault_code inside {[8'h01:8'h20]})
        else $error("hall code missing");
    frame_long_a: assert property (idle && fbus.frame_too_long |=> fault_code inside {[8'h01:8'h38]})
        else $error("long frame code missing");
    cover property (fault_code == 8'h02);
    cover property (clr_wr && (fault_code != 8'h00));
    cover property (psel && penable && pslverr);
endmodule : sfm_monitor_properties

bind sfm_monitor sfm_monitor_properties i_props (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drv(drv), .enc(enc), .fbus(fbus), .fault_code(fault_code), .fault_active(fault_active));

// File: test/sfm_enc_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Encoder link model
// ----------------------------------------
module sfm_enc_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [3:0]  err_sel,
    output sfm_pkg::sfm_enc_t enc
);
    import sfm_pkg::*;
    logic [2:0] gap_reg;
    logic       send;
    assign send = run && (gap_reg == 3'h7);
    always_ff @(posedge mclk) begin
        gap_reg <= rst_n ? gap_reg + 3'h1 : 3'h0;
        if (!rst_n) begin
            enc <= 5'h0A;
        end else if (send) begin
            enc.frame_valid <= 1'b1;
            enc.crc_ok      <= !err_sel[0];
            enc.cf_err      <= err_sel[1];
            enc.bat_low     <= err_sel[2];
            enc.bat_err     <= err_sel[3];
        end else begin
            enc <= {1'b0, ~enc[3:0]};
        end
    end
endmodule : sfm_enc_model

// File: test/sfm_monitor_tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// Fault monitor testbench
// ----------------------------------------
module sfm_monitor_tb_top;
    import sfm_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, run = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, err_seen, fault_active;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0]  fault_code;
    logic [3:0]  err_sel = 4'h0;
    sfm_drive_t  drv, base;
    sfm_enc_t    enc;
    sfm_fbus_t   fbus = 2'h0;
    int          errors = 0, compares = 0;
    always #2 mclk = ~mclk;
    sfm_monitor i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drv(drv),
        .enc(enc), .fbus(fbus), .fault_code(fault_code), .fault_active(fault_active));
    sfm_enc_model i_enc (.mclk(mclk), .rst_n(rst_n), .run(run), .err_sel(err_sel), .enc(enc));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        err_seen = pslverr;
        rd       = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rchk
    task automatic fault(input logic [7:0] code, input int n, input logic [11:0] ra = 12'h03C);
        repeat (n) @(posedge mclk);
        check(32'(fault_code), 32'(code));
        check(32'(fault_active), 32'(code != 8'h00));
        drv     <= base;
        fbus    <= 2'h0;
        err_sel <= 4'h0;
        run     <= 1'b1;
        apb(1'b1, ra, 32'h0000_0000);
        repeat (10) @(posedge mclk);
        apb(1'b1, 12'h000, 32'h0000_0003);
        check(32'(fault_code), 32'h0000_0000);
        $display("Fault test %0d done", code);
    endtask : fault
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        base                    = '0;
        base.inhibit_fwd_on     = 1'b1;
        base.inhibit_rev_on     = 1'b1;
        base.brake_released     = 1'b1;
        base.hall_phase_signals = 3'h1;
        drv                     = base;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(12'h000, 32'h0000_0002);
        rchk(12'h008, 32'h0000_1388);
        rchk(12'h01C, 32'h0000_0003);
        rchk(12'h03C, 32'h0000_0000);
        check(32'(err_seen), 32'h0000_0001);
        $display("Register test done");
        drv.speed <= 32'h0000_1388;
        fault(8'h00, 4);
        drv.speed <= 32'h0000_1389;
        fault(8'h01, 4);
        drv.over_volt <= 1'b1;
        fault(8'h02, 4);
        drv.under_volt <= 1'b1;
        fault(8'h03, 4);
        drv.pos_dev <= 32'h0001_0001;
        fault(8'h04, 4);
        apb(1'b1, 12'h010, 32'h0000_0014);
        drv.spd_sat <= 1'b1;
        fault(8'h06, 40);
        drv.inhibit_fwd_on <= 1'b0;
        drv.inhibit_rev_on <= 1'b0;
        fault(8'h07, 4);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        drv.pos_dev <= 32'h4000_0000;
        fault(8'h00, 4);
        drv.pos_dev <= 32'hBFFF_FFFF;
        fault(8'h08, 4);
        drv.relay_sense <= 1'b1;
        fault(8'h12, 4);
        drv.cmd_pulse      <= 1'b1;
        drv.brake_released <= 1'b0;
        fault(8'h13, 4);
        apb(1'b1, 12'h028, 32'h0000_0003);
        fault(8'h16, 4, 12'h028);
        apb(1'b1, 12'h018, 32'h0000_0014);
        drv.torque <= 32'h0000_8001;
        fault(8'h1D, 40);
        drv.hall_phase_signals <= 3'h7;
        fault(8'h20, 4);
        drv.motor_model <= 8'h05;
        fault(8'h29, 4);
        err_sel <= 4'h4;
        fault(8'h34, 24);
        err_sel <= 4'hC;
        fault(8'h35, 24);
        err_sel <= 4'h1;
        fault(8'h37, 40);
        fbus.frame_too_long <= 1'b1;
        fault(8'h38, 4);
        fbus.frame_bad_format <= 1'b1;
        fault(8'h39, 4);
        apb(1'b1, 12'h024, 32'h0002_0000);
        fault(8'h3A, 4, 12'h024);
        err_sel <= 4'h2;
        fault(8'h3B, 40);
        drv.over_volt <= 1'b1;
        repeat (3) @(posedge mclk);
        drv.speed <= 32'h0000_2000;
        rchk(12'h004, 32'h0000_0102);
        drv.speed <= 32'h0000_0000;
        apb(1'b1, 12'h000, 32'h0000_0003);
        check(32'(fault_code), 32'h0000_0002);
        fault(8'h02, 1);
        apb(1'b1, 12'h000, 32'h0000_0000);
        drv.motor_model <= 8'h05;
        fault(8'h00, 4);
        apb(1'b1, 12'h030, 32'h0000_0028);
        run <= 1'b0;
        fault(8'h33, 60);
        rst_n <= 1'b0;
        run   <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b1, 12'h030, 32'h0000_0028);
        fault(8'h32, 60);
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule : sfm_monitor_tb_top
